// [common/sccr_pkg.sv]
// Function
// [RULE1] User bus runs at oscillator or PLL divided by four
// [RULE2] Bus clock is clock generator output divided by two
// [RULE3] Power-up or low voltage holds clocks 4096 cycles
// [RULE4] Reset pin driven low during start-up timeout
// [RULE5] Stop exit counts delay, processor clocks stay off
// [RULE6] Stop exit delay is 4096 or 32 cycles
// [RULE7] Wait stops processor clocks, two module clock sets run
// [RULE8] Every reset source asserts internal reset and vector
// [RULE9] Internal reset returns registers to defaults
// [RULE10] Internal reset clears system counter, pin reset does not
// [RULE11] Reset cause register records each source by bit
// [RULE12] Low reset pin is asynchronous and halts processing
// [RULE13] Pin held low 67 cycles sets pin flag
// [RULE14] After power-up or low voltage, 4163 cycles needed
// [RULE15] Break status holds break-during-wait flag at bit one
// [RULE16] Break flag control holds clear enable at bit seven
// [RULE17] Up to 24 interrupt sources are handled
// [RULE18] Internal reset drives pin 32 cycles, then 32 more
// [RULE19] System counter is 13 bits on oscillator clock
// [RULE20] Short stop recovery selects 32 cycles, else 4096
package sccr_pkg;
  // Oscillator rate and derived cycle counts
  localparam int OSC_HZ = 40_000_000;
  localparam int SYS_CNT_W = 13;
  localparam logic [12:0] POR_LAST = 13'h0fff; // 4096 cycles counted from zero
  localparam logic [12:0] STOP_LONG_LAST = 13'h0fff;
  localparam logic [12:0] STOP_SHORT_LAST = 13'h001f; // 32 cycles
  localparam logic [5:0] PHASE_LAST = 6'h1f; // 32 cycles per reset phase
  localparam logic [12:0] PIN_MIN_NORMAL = 13'h0043; // 67 = 64 + 3
  localparam logic [12:0] PIN_MIN_POWER = 13'h1043; // 4163 = 4096 + 64 + 3
  // Register indices, byte address is four times the index
  localparam logic [15:0] IDX_BREAK_STATUS = 16'hfe00;
  localparam logic [15:0] IDX_RESET_CAUSE = 16'hfe01;
  localparam logic [15:0] IDX_BREAK_FLAG_CONTROL = 16'hfe03;
  // Field positions
  localparam int CAUSE_POWER = 7;
  localparam int CAUSE_PIN = 6;
  localparam int CAUSE_WATCHDOG = 5;
  localparam int CAUSE_OPCODE = 4;
  localparam int CAUSE_ADDRESS = 3;
  localparam int CAUSE_LOW_VOLT = 1;
  localparam int BRK_WAIT_BIT = 1;
  localparam int BRK_CLR_EN_BIT = 7;
  localparam logic [7:0] CAUSE_MASK = 8'hfa; // Bits 2 and 0 read zero
  localparam logic [7:0] CAUSE_POWER_ONLY = 8'h80;
  // Reset vectors
  localparam logic [15:0] VEC_USER = 16'hfffe;
  localparam logic [15:0] VEC_MONITOR = 16'hfefe;
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] HRDATA_IDLE = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_POR_HOLD, ST_PIN_DRIVE, ST_INTERNAL_RESET_TAIL, ST_RUN, ST_STOP, ST_STOP_EXIT, ST_EXT_RST
  } sccr_state_e;
endpackage

// [src/sccr_top.sv]
module sccr_top #(
  parameter int IRQ_SOURCES = 24 // see [RULE17]
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Reset sources
  input wire logic POWER_UP_PULSE_I,
  input wire logic LOW_VOLTAGE_TRIP_I,
  input wire logic WATCHDOG_TIMEOUT_I,
  input wire logic BAD_OPCODE_FLAG_I,
  input wire logic BAD_ADDRESS_FLAG_I,
  // External reset pin, active low
  input wire logic RST_N_PIN_I,
  output logic RST_N_PIN_O,
  output logic RST_N_PIN_OE_O,
  // Clock generator
  input wire logic PLL_SEL_I,
  input wire logic PLL_TICK_I,
  // Mode and option inputs
  input wire logic MONITOR_MODE_I,
  input wire logic SHORT_STOP_RECOVERY_I,
  input wire logic STOP_REQ_I,
  input wire logic WAIT_REQ_I,
  input wire logic BREAK_REQ_I,
  input wire logic BREAK_ACTIVE_I,
  input wire logic BREAK_WAIT_SET_I,
  input wire logic [IRQ_SOURCES-1:0] IRQ_REQ_I,
  // Clock enables, reset and interrupt outputs
  output logic CGM_TICK_O,
  output logic BUS_TICK_O,
  output logic CPU_TICK_O,
  output logic INTERNAL_RESET_O,
  output logic [15:0] VECTOR_O,
  output logic IRQ_ANY_O,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O
);

  sccr_pkg::sccr_state_e state;
  sccr_pkg::sccr_state_e next_state;
  logic [12:0] sys_cnt;
  logic [5:0] phase_cnt;
  logic [12:0] pin_low_cnt;
  logic pin_s1, pin_s2, pin_s3, pin_level;
  logic power_origin;
  logic cgm_div;
  logic bus_div;
  logic [7:0] reset_cause;
  logic break_wait_flag;
  logic break_clear_enable;
  logic wr_pend;
  logic [15:0] wr_idx;

  // Source decode
  wire power_src = POWER_UP_PULSE_I | LOW_VOLTAGE_TRIP_I;
  wire other_src = WATCHDOG_TIMEOUT_I | BAD_OPCODE_FLAG_I | BAD_ADDRESS_FLAG_I;
  wire irq_any = |IRQ_REQ_I;
  wire in_reset = (state == sccr_pkg::ST_POR_HOLD) | (state == sccr_pkg::ST_PIN_DRIVE) |
                  (state == sccr_pkg::ST_INTERNAL_RESET_TAIL) | (state == sccr_pkg::ST_EXT_RST);
  wire drive_pin = (state == sccr_pkg::ST_POR_HOLD) | (state == sccr_pkg::ST_PIN_DRIVE);
  wire pin_low_ext = ~pin_level & ~in_reset; // Own drive is ignored while in reset
  wire [12:0] stop_last = SHORT_STOP_RECOVERY_I ? sccr_pkg::STOP_SHORT_LAST :
                          sccr_pkg::STOP_LONG_LAST; // see [RULE6] see [RULE20]
  wire [12:0] pin_min = power_origin ? sccr_pkg::PIN_MIN_POWER : sccr_pkg::PIN_MIN_NORMAL; // see [RULE14]
  wire pin_flag_hit = (pin_low_cnt == pin_min); // see [RULE13]

  // Clock generator source tick: oscillator every cycle, or the PLL tick
  wire cgm_src = PLL_SEL_I ? PLL_TICK_I : 1'b1;
  wire cgm_tick = cgm_src & cgm_div; // see [RULE2]
  wire bus_tick = cgm_tick & bus_div; // see [RULE1]
  wire run_clocks = (state == sccr_pkg::ST_RUN);

  // Bus decode
  wire addr_phase = HSEL_I & HREADY_I & (HTRANS_I == sccr_pkg::HTRANS_NONSEQ);
  wire [15:0] a_idx = HADDR_I[17:2];
  wire a_hi_zero = (HADDR_I[31:18] == 14'h0000);
  wire rd_cause = addr_phase & ~HWRITE_I & a_hi_zero & (a_idx == sccr_pkg::IDX_RESET_CAUSE);
  wire wr_brk = wr_pend & (wr_idx == sccr_pkg::IDX_BREAK_STATUS);
  wire wr_bfc = wr_pend & (wr_idx == sccr_pkg::IDX_BREAK_FLAG_CONTROL);
  // Clearing the wait flag is allowed outside break, or in break with clear enabled
  wire brk_clear = wr_brk & ~HWDATA_I[sccr_pkg::BRK_WAIT_BIT] & (~BREAK_ACTIVE_I | break_clear_enable);
  wire [7:0] brk_view = {6'h00, break_wait_flag, 1'b0}; // see [RULE15]
  wire [7:0] bfc_view = {break_clear_enable, 7'h00}; // see [RULE16]
  wire [7:0] cause_view = reset_cause & sccr_pkg::CAUSE_MASK; // see [RULE11]
  wire [7:0] rd_byte = ~a_hi_zero ? 8'h00 :
                       (a_idx == sccr_pkg::IDX_BREAK_STATUS) ? brk_view :
                       (a_idx == sccr_pkg::IDX_RESET_CAUSE) ? cause_view :
                       (a_idx == sccr_pkg::IDX_BREAK_FLAG_CONTROL) ? bfc_view : 8'h00;

  // Pin synchroniser, level only changes when the last two stages agree
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
      pin_level <= 1'b1;
    end else begin
      pin_s1 <= RST_N_PIN_I; // see [RULE12]
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
    end
  end

  // Reset and mode sequencer; power sources win over all others
  always_comb begin
    next_state = state;
    unique case (state)
      sccr_pkg::ST_POR_HOLD: begin
        if (sys_cnt == sccr_pkg::POR_LAST) begin
          next_state = sccr_pkg::ST_PIN_DRIVE; // see [RULE3]
        end
      end
      sccr_pkg::ST_PIN_DRIVE: begin
        if (phase_cnt == sccr_pkg::PHASE_LAST) begin
          next_state = sccr_pkg::ST_INTERNAL_RESET_TAIL; // see [RULE18]
        end
      end
      sccr_pkg::ST_INTERNAL_RESET_TAIL: begin
        if (phase_cnt == sccr_pkg::PHASE_LAST) begin
          next_state = sccr_pkg::ST_RUN;
        end
      end
      sccr_pkg::ST_RUN: begin
        if (STOP_REQ_I) begin
          next_state = sccr_pkg::ST_STOP;
        end
      end
      sccr_pkg::ST_STOP: begin
        if (irq_any | BREAK_REQ_I) begin
          next_state = sccr_pkg::ST_STOP_EXIT; // see [RULE5]
        end
      end
      sccr_pkg::ST_STOP_EXIT: begin
        if (sys_cnt == stop_last) begin
          next_state = sccr_pkg::ST_RUN;
        end
      end
      sccr_pkg::ST_EXT_RST: begin
        if (pin_level) begin
          next_state = sccr_pkg::ST_INTERNAL_RESET_TAIL;
        end
      end
    endcase
    if (pin_low_ext) begin
      next_state = sccr_pkg::ST_EXT_RST; // see [RULE12]
    end
    if (other_src & (state != sccr_pkg::ST_POR_HOLD)) begin
      next_state = sccr_pkg::ST_PIN_DRIVE; // see [RULE8]
    end
    if (power_src) begin
      next_state = sccr_pkg::ST_POR_HOLD;
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state <= sccr_pkg::ST_POR_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Phase counter restarts on every state change
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      phase_cnt <= 6'h00;
    end else if (next_state != state) begin
      phase_cnt <= 6'h00;
    end else begin
      phase_cnt <= phase_cnt + 6'h01;
    end
  end

  // System counter: cleared by internal sources, held at zero throughout stop.
  // A pin reset leaves it running, so the watchdog prescale is not disturbed.
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sys_cnt <= 13'h0000;
    end else if (power_src | other_src) begin
      sys_cnt <= 13'h0000; // see [RULE10]
    end else if (state == sccr_pkg::ST_STOP) begin
      sys_cnt <= 13'h0000;
    end else begin
      sys_cnt <= sys_cnt + 13'h0001; // see [RULE19]
    end
  end

  // Pin low time, saturating at the longest threshold
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pin_low_cnt <= 13'h0000;
    end else if (pin_level) begin
      pin_low_cnt <= 13'h0000;
    end else if (pin_low_cnt != sccr_pkg::PIN_MIN_POWER) begin
      pin_low_cnt <= pin_low_cnt + 13'h0001;
    end
  end

  // Power origin selects the longer pin threshold until the part runs
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      power_origin <= 1'b1;
    end else if (power_src) begin
      power_origin <= 1'b1;
    end else if (state == sccr_pkg::ST_RUN) begin
      power_origin <= 1'b0;
    end
  end

  // Reset cause: power-up clears the rest; read clears, but new causes win
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      reset_cause <= sccr_pkg::CAUSE_POWER_ONLY;
    end else if (POWER_UP_PULSE_I) begin
      reset_cause <= sccr_pkg::CAUSE_POWER_ONLY; // see [RULE11]
    end else begin
      reset_cause <= (rd_cause ? 8'h00 : reset_cause) |
        ({7'h00, LOW_VOLTAGE_TRIP_I} << sccr_pkg::CAUSE_LOW_VOLT) |
        ({7'h00, WATCHDOG_TIMEOUT_I} << sccr_pkg::CAUSE_WATCHDOG) |
        ({7'h00, BAD_OPCODE_FLAG_I} << sccr_pkg::CAUSE_OPCODE) |
        ({7'h00, BAD_ADDRESS_FLAG_I} << sccr_pkg::CAUSE_ADDRESS) |
        ({7'h00, pin_flag_hit} << sccr_pkg::CAUSE_PIN); // see [RULE13]
    end
  end

  // Break registers, returned to defaults while internal reset holds
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      break_wait_flag <= 1'b0;
      break_clear_enable <= 1'b0;
    end else if (in_reset) begin
      break_wait_flag <= 1'b0; // see [RULE9]
      break_clear_enable <= 1'b0;
    end else begin
      break_wait_flag <= BREAK_WAIT_SET_I | (break_wait_flag & ~brk_clear);
      if (wr_bfc) begin
        break_clear_enable <= HWDATA_I[sccr_pkg::BRK_CLR_EN_BIT];
      end
    end
  end

  // Bus slave: zero wait states, read data caught in the address phase
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      wr_pend <= 1'b0;
      wr_idx <= 16'h0000;
      HRDATA_O <= sccr_pkg::HRDATA_IDLE;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end else begin
      wr_pend <= addr_phase & HWRITE_I & a_hi_zero;
      wr_idx <= a_idx;
      HRDATA_O <= (addr_phase & ~HWRITE_I) ? {24'h000000, rd_byte} : sccr_pkg::HRDATA_IDLE;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
  end

  // Clock dividers: half rate generator output, quarter rate bus
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cgm_div <= 1'b0;
      bus_div <= 1'b0;
    end else begin
      if (cgm_src) begin
        cgm_div <= ~cgm_div;
      end
      if (cgm_tick) begin
        bus_div <= ~bus_div;
      end
    end
  end

  // Output enables; wait keeps both module sets but stops the processor
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      CGM_TICK_O <= 1'b0;
      BUS_TICK_O <= 1'b0;
      CPU_TICK_O <= 1'b0;
      INTERNAL_RESET_O <= 1'b1;
      RST_N_PIN_O <= 1'b0;
      RST_N_PIN_OE_O <= 1'b1;
      VECTOR_O <= sccr_pkg::VEC_USER;
      IRQ_ANY_O <= 1'b0;
    end else begin
      CGM_TICK_O <= cgm_tick & run_clocks; // see [RULE7]
      BUS_TICK_O <= bus_tick & run_clocks; // see [RULE7]
      CPU_TICK_O <= bus_tick & run_clocks & ~WAIT_REQ_I; // see [RULE7]
      INTERNAL_RESET_O <= in_reset; // see [RULE8]
      RST_N_PIN_O <= 1'b0;
      RST_N_PIN_OE_O <= drive_pin; // see [RULE4]
      VECTOR_O <= MONITOR_MODE_I ? sccr_pkg::VEC_MONITOR : sccr_pkg::VEC_USER; // see [RULE8]
      IRQ_ANY_O <= irq_any; // see [RULE17]
    end
  end

  // Checks
  AST_POR_PIN: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RULE4]
    state == sccr_pkg::ST_POR_HOLD |=> RST_N_PIN_OE_O && !RST_N_PIN_O) else $error("pin not driven in startup");
  AST_POR_LEN: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RULE3]
    state == sccr_pkg::ST_POR_HOLD && sys_cnt != sccr_pkg::POR_LAST && !other_src && !power_src
    |=> state == sccr_pkg::ST_POR_HOLD) else $error("startup ended early");
  AST_CGM_DIV: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RULE2]
    CGM_TICK_O |=> !CGM_TICK_O) else $error("generator tick not halved");
  AST_BUS_DIV: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RULE1]
    BUS_TICK_O |=> !BUS_TICK_O [*3]) else $error("bus tick faster than quarter");
  AST_STOP_OFF: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RULE5]
    state == sccr_pkg::ST_STOP_EXIT |=> !CPU_TICK_O && !BUS_TICK_O) else $error("clocks during stop exit");
  AST_STOP_SHORT: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RULE20]
    state == sccr_pkg::ST_STOP_EXIT && SHORT_STOP_RECOVERY_I && sys_cnt == sccr_pkg::STOP_SHORT_LAST
    && !pin_low_ext && !other_src && !power_src |=> state == sccr_pkg::ST_RUN) else $error("short stop delay wrong");
  AST_WAIT: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RULE7]
    WAIT_REQ_I |=> !CPU_TICK_O) else $error("processor clock in wait");
  AST_DRIVE_END: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RULE18]
    state == sccr_pkg::ST_PIN_DRIVE && phase_cnt == sccr_pkg::PHASE_LAST && !other_src && !power_src
    |=> state == sccr_pkg::ST_INTERNAL_RESET_TAIL ##1 !RST_N_PIN_OE_O) else $error("pin drive phase wrong");
  AST_CNT_CLR: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RULE10]
    other_src |=> sys_cnt == 13'h0000) else $error("counter not cleared");
  AST_CAUSE_ZERO: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RULE11]
    HRDATA_O[2] == 1'b0 && HRDATA_O[0] == 1'b0) else $error("reserved cause bits set");
  AST_PIN_FLAG: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RULE13]
    $rose(reset_cause[sccr_pkg::CAUSE_PIN]) |-> $past(pin_low_cnt) == $past(pin_min)) else $error("pin flag early");
  AST_INTERNAL_RESET: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RULE8]
    WATCHDOG_TIMEOUT_I |=> ##1 INTERNAL_RESET_O) else $error("no internal reset");
  COV_STOP: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    state == sccr_pkg::ST_STOP_EXIT ##1 state == sccr_pkg::ST_RUN);
  COV_EXT: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) $rose(reset_cause[sccr_pkg::CAUSE_PIN]));
  COV_INT: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
    state == sccr_pkg::ST_INTERNAL_RESET_TAIL ##1 state == sccr_pkg::ST_RUN);

endmodule // sccr_top

// [sim/sccr_far_model.sv]
module sccr_far_model (
  input wire logic clk_i,
  input wire logic pin_drive_i,
  input wire logic pin_oe_i,
  input wire logic ext_low_i,
  output logic pin_level_o,
  output logic pll_tick_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] div;
  // Pull-up on the pin, so it reads high unless some party pulls it down
  assign pin_level_o = ((pin_oe_i & ~pin_drive_i) | ext_low_i) ? 1'b0 : 1'b1;
  // PLL enable every third cycle, slower than the oscillator on purpose
  initial begin
    div = 2'h0;
    pll_tick_o = 1'b0;
    forever begin
      @(posedge clk_i);
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      pll_tick_o <= (div == 2'h2);
    end
  end
endmodule // sccr_far_model

// [sim/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] A_BRK = {14'h0, sccr_pkg::IDX_BREAK_STATUS, 2'h0};
  localparam logic [31:0] A_CAU = {14'h0, sccr_pkg::IDX_RESET_CAUSE, 2'h0};
  localparam logic [31:0] A_CTL = {14'h0, sccr_pkg::IDX_BREAK_FLAG_CONTROL, 2'h0};
  localparam logic [31:0] A_BAD = 32'h0003_f808;
  logic clk, rst, psel, mon, ssr, wt, brq, bact, hsel, hwrite, ext_low;
  logic [7:0] src;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, rd;
  wire pin_lvl, pll_tick, pin_o, pin_oe, cgm, bus, cpu, internal_reset, irq_any, hready, hresp;
  wire [15:0] vec;
  wire [31:0] hrdata;
  int mismatches, compares, n1, n2, n3;
  // Oscillator at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  sccr_top sccr_top_inst (.CLK_I(clk), .SYS_RST_I(rst), .POWER_UP_PULSE_I(src[0]), .LOW_VOLTAGE_TRIP_I(src[1]),
    .WATCHDOG_TIMEOUT_I(src[2]), .BAD_OPCODE_FLAG_I(src[3]), .BAD_ADDRESS_FLAG_I(src[4]),
    .RST_N_PIN_I(pin_lvl), .RST_N_PIN_O(pin_o), .RST_N_PIN_OE_O(pin_oe), .PLL_SEL_I(psel),
    .PLL_TICK_I(pll_tick), .MONITOR_MODE_I(mon), .SHORT_STOP_RECOVERY_I(ssr), .STOP_REQ_I(src[5]),
    .WAIT_REQ_I(wt), .BREAK_REQ_I(brq), .BREAK_ACTIVE_I(bact), .BREAK_WAIT_SET_I(src[6]),
    .IRQ_REQ_I({src[7], 23'h0}), .CGM_TICK_O(cgm), .BUS_TICK_O(bus), .CPU_TICK_O(cpu),
    .INTERNAL_RESET_O(internal_reset), .VECTOR_O(vec), .IRQ_ANY_O(irq_any), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp));
  sccr_far_model sccr_far_model_inst (.clk_i(clk), .pin_drive_i(pin_o), .pin_oe_i(pin_oe),
    .ext_low_i(ext_low), .pin_level_o(pin_lvl), .pll_tick_o(pll_tick));
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task check_rng(input string what, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Single word transfer; the address phase is held until hready is seen high
  task xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= sccr_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask
  task pulse(input int b);
    @(posedge clk);
    src[b] <= 1'b1;
    @(posedge clk);
    src[b] <= 1'b0;
  endtask
  // Samples 1 ns after each edge so that the edge's own updates have landed
  task cnt(input int n);
    n1 = 0;
    n2 = 0;
    n3 = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      n1 += int'(cgm === 1'b1);
      n2 += int'(bus === 1'b1);
      n3 += int'(cpu === 1'b1);
    end
  endtask
  // Length of the pin drive phase and of the internal reset tail after it
  task seq;
    n1 = 0;
    n2 = 0;
    while (pin_oe !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    while (pin_oe === 1'b1) begin
      @(posedge clk);
      #1;
      n1++;
    end
    while (internal_reset === 1'b1) begin
      @(posedge clk);
      #1;
      n2++;
    end
  endtask
  task endt(input string name);
    $display("test %s done", name);
  endtask
  // Watchdog: the whole run needs about 18000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    finish_test();
  end
  initial begin
    {rst, psel, mon, ssr, wt, brq, bact, hsel, hwrite, ext_low} = 10'h200;
    src = 8'h00;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    mismatches = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("pin level in start-up", 32'h0, {31'h0, pin_lvl});
    check("internal reset in start-up", 32'h1, {31'h0, internal_reset});
    seq();
    check_rng("start-up hold", 4126, 4131, n1);
    check_rng("start-up tail", 32, 32, n2);
    rdchk("cause after power-up", A_CAU, 32'h80);
    rdchk("cause cleared", A_CAU, 32'h0);
    check("user vector", 32'(sccr_pkg::VEC_USER), 32'(vec));
    check("bus response", 32'h0, {31'h0, hresp});
    check("bus ready", 32'h1, {31'h0, hready});
    endt("power up");
    cnt(64);
    check_rng("osc clock gen ticks", 31, 33, n1);
    check_rng("osc bus ticks", 15, 17, n2);
    psel <= 1'b1;
    cnt(96);
    check_rng("pll clock gen ticks", 15, 17, n1);
    check_rng("pll bus ticks", 7, 9, n2);
    psel <= 1'b0;
    wt <= 1'b1;
    cnt(64);
    check_rng("wait cpu ticks", 0, 0, n3);
    check_rng("wait bus ticks", 15, 17, n2);
    check_rng("wait clock gen ticks", 31, 33, n1);
    wt <= 1'b0;
    src[7] <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("interrupt any", 32'h1, {31'h0, irq_any});
    src[7] <= 1'b0;
    endt("clocks");
    pulse(6);
    rdchk("break wait set", A_BRK, 32'h2);
    bact <= 1'b1;
    xfer(1'b1, A_BRK, 32'h0);
    rdchk("break wait guarded", A_BRK, 32'h2);
    xfer(1'b1, A_CTL, 32'hffff_ffff);
    rdchk("clear enable", A_CTL, 32'h80);
    xfer(1'b1, A_BRK, 32'h0);
    rdchk("break wait cleared", A_BRK, 32'h0);
    bact <= 1'b0;
    xfer(1'b1, A_CAU, 32'hff);
    rdchk("cause read only", A_CAU, 32'h0);
    rdchk("unmapped", A_BAD, 32'h0);
    endt("break registers");
    for (int b = 2; b <= 4; b++) begin
      mon <= (b == 3);
      pulse(b);
      seq();
      check_rng("drive phase", 32, 32, n1);
      check_rng("tail phase", 32, 32, n2);
      check("vector", (b == 3) ? 32'(sccr_pkg::VEC_MONITOR) : 32'(sccr_pkg::VEC_USER), 32'(vec));
      rdchk("cause internal", A_CAU, 32'h80 >> b);
    end
    mon <= 1'b0;
    rdchk("control back to default", A_CTL, 32'h0);
    endt("internal resets");
    @(posedge clk);
    ext_low <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check("pin reset halts", 32'h1, {31'h0, internal_reset});
    cnt(10);
    check_rng("cpu ticks in pin reset", 0, 0, n3);
    ext_low <= 1'b0;
    while (internal_reset === 1'b1) @(posedge clk);
    rdchk("short pin pulse", A_CAU, 32'h0);
    @(posedge clk);
    ext_low <= 1'b1; // Held well past the minimum low time
    repeat (100) @(posedge clk);
    ext_low <= 1'b0;
    while (internal_reset === 1'b1) @(posedge clk);
    rdchk("long pin pulse", A_CAU, 32'h40);
    endt("pin reset");
    for (int s = 1; s >= 0; s--) begin
      ssr <= s[0];
      pulse(5);
      cnt(20);
      check_rng("ticks in stop", 0, 0, n2);
      @(posedge clk);
      brq <= s[0]; // Break wakes the short case, an interrupt the long one
      src[7] <= ~s[0];
      @(posedge clk);
      brq <= 1'b0;
      src[7] <= 1'b0;
      n1 = 0;
      while (cpu !== 1'b1) begin
        @(posedge clk);
        #1;
        n1++;
      end
      check_rng("stop exit", s ? 32 : 4096, s ? 40 : 4104, n1);
    end
    endt("stop");
    pulse(1);
    seq();
    check_rng("low voltage hold", 4126, 4132, n1);
    check_rng("low voltage tail", 32, 32, n2);
    rdchk("cause low voltage", A_CAU, 32'h2);
    endt("low voltage");
    pulse(2);
    pulse(0);
    seq();
    check_rng("power pulse hold", 4126, 4132, n1);
    check_rng("power pulse tail", 32, 32, n2);
    rdchk("power pulse clears causes", A_CAU, 32'h80);
    endt("power pulse");
    finish_test();
  end
endmodule // testbench
